// >>> hdl/boot_strapped_clock_tree.sv
// Clock tree: strap-selected ratios, divided and gated clocks, APB registers.
// Assumes pclk is the multiplier loop output, eight times the master rate.
// Summary of operation
// - All clocks derive from one master clock
// - Core ratio from four straps, 2 to 18
// - Strap bit 2 low: bus x4, high: x1
// - Peripheral clock is half system bus clock
// - External clock is bus clock over 4,3,2,1
// - Enable bit clear stops external clock pulses
// - SDRAM clocks run at system bus rate
// - Each SDRAM clock gated by own bit
// - SDRAM read data latched by feedback clock
`timescale 1ns/10ps
`default_nettype none
`include "clock_tree_defines.svh"

module boot_strapped_clock_tree (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [3:0]  strap_core_ratio,
    input  wire logic        strap_bus_mult,
    input  wire logic [1:0]  strap_ext_div,
    input  wire logic        sdram_feedback_clock,
    input  wire logic [31:0] sdram_read_data,
    output logic      [5:0]  core_ratio_x2,
    output logic             system_bus_clock,
    output logic             peripheral_bus_clock,
    output logic             external_bus_clock_out,
    output logic      [3:0]  sdram_clock_out
);
    logic [3:0]  core_s1_r, core_s2_r;
    logic        bus_s1_r, bus_s2_r;
    logic [1:0]  ext_s1_r, ext_s2_r;
    logic [3:0]  core_ratio_select_r;
    logic        bus_mult_sel_r;
    logic [1:0]  ext_clock_divider_select_r;
    logic        strap_valid_r;
    logic        ratio_loaded_r;
    logic [31:0] pin_config_register_r;
    logic [1:0]  step_cnt_r;
    logic        sys_r;
    logic        sys_nxt;
    logic        sys_step;
    logic [2:0]  half_cnt_r;
    logic [2:0]  half_nxt;
    logic [2:0]  half_top;
    logic [2:0]  div_n;
    logic        per_r;
    logic        ext_r;
    logic [3:0]  sdram_r;
    logic [5:0]  ratio_r;
    logic        fb_s1_r, fb_s2_r, fb_s3_r;
    logic [31:0] data_s1_r, data_s2_r;
    logic [31:0] sdram_data_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] rd_nxt;
    logic        map_hit;
    logic        wr_en;

    function automatic clock_tree_pkg::ratio_x2_t ratio_of(
        input clock_tree_pkg::core_ratio_select_t sel);
        unique case (sel)
            4'hf:    ratio_of = 6'h04;
            4'he:    ratio_of = 6'h05;
            4'hc:    ratio_of = 6'h06;
            4'hd:    ratio_of = 6'h08;
            4'h7:    ratio_of = 6'h09;
            4'hb:    ratio_of = 6'h10;
            4'ha:    ratio_of = 6'h14;
            4'h9:    ratio_of = 6'h18;
            4'h8:    ratio_of = 6'h20;
            4'h3:    ratio_of = 6'h24;
            default: ratio_of = 6'h04;
        endcase
    endfunction

    // Two-flop synchronisers for strap pins
    always_ff @(posedge pclk) begin
        core_s1_r <= strap_core_ratio;
        core_s2_r <= core_s1_r;
        bus_s1_r  <= strap_bus_mult;
        bus_s2_r  <= bus_s1_r;
        ext_s1_r  <= strap_ext_div;
        ext_s2_r  <= ext_s1_r;
    end

    // Strap capture while reset is low, held after release
    always_ff @(posedge pclk) begin
        if (!presetn) begin
            core_ratio_select_r        <= core_s2_r;
            bus_mult_sel_r             <= bus_s2_r;
            ext_clock_divider_select_r <= ext_s2_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ratio_loaded_r <= 1'b0;
            strap_valid_r  <= 1'b0;
            ratio_r        <= 6'h04;
        end else begin
            // Valid only once the new ratio has settled
            ratio_loaded_r <= 1'b1;
            strap_valid_r  <= ratio_loaded_r;
            ratio_r       <= ratio_of(core_ratio_select_r);
        end
    end

    // System bus clock from the single multiplier loop clock
    assign sys_step = (step_cnt_r == (bus_mult_sel_r ? `SYS_STEP_SLOW
                                                     : `SYS_STEP_FAST));
    assign sys_nxt  = sys_step ? ~sys_r : sys_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_cnt_r <= 2'h0;
            sys_r      <= 1'b0;
        end else begin
            step_cnt_r <= sys_step ? 2'h0 : step_cnt_r + 2'h1;
            sys_r      <= sys_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_r <= 1'b0;
        end else if (sys_step && !sys_r) begin
            per_r <= ~per_r;
        end
    end

    // External clock divider: high for n of 2n bus half periods
    assign div_n    = 3'h4 - {1'b0, ext_clock_divider_select_r};
    assign half_top = {div_n[1:0], 1'b0} - 3'h1;
    assign half_nxt = !sys_step ? half_cnt_r
                    : (half_cnt_r == half_top) ? 3'h0
                    : half_cnt_r + 3'h1;

    // High on half periods 1 to n, so its rise meets a bus clock rise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_cnt_r <= 3'h0;
            ext_r      <= 1'b0;
        end else begin
            half_cnt_r <= half_nxt;
            ext_r      <= pin_config_register_r[`PIN_CFG_EXT_EN_BIT] &&
                          half_nxt != 3'h0 && half_nxt <= div_n;
        end
    end

    generate
        for (genvar i = 0; i < 4; i++) begin : g_sdram
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sdram_r[i] <= 1'b0;
                end else begin
                    sdram_r[i] <= sys_nxt &&
                        pin_config_register_r[`PIN_CFG_SDRAM_LSB + i];
                end
            end
        end
    endgenerate

    // Feedback clock edge latches SDRAM read data
    always_ff @(posedge pclk) begin
        fb_s1_r <= sdram_feedback_clock;
        fb_s2_r <= fb_s1_r;
        fb_s3_r <= fb_s2_r;
        // Data pins take the same two stages as the feedback pin
        data_s1_r <= sdram_read_data;
        data_s2_r <= data_s1_r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdram_data_r <= 32'h0000_0000;
        end else if (fb_s2_r && !fb_s3_r) begin
            sdram_data_r <= data_s2_r;
        end
    end

    // APB slave, one wait-free access phase
    assign map_hit = (paddr == `PIN_CFG_OFFSET) ||
                     (paddr == `CHIP_CFG_OFFSET) ||
                     (paddr == `SDRAM_DATA_OFFSET);
    assign wr_en   = psel && penable && pready_r && pwrite && map_hit;

    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (paddr == `PIN_CFG_OFFSET) begin
            rd_nxt = pin_config_register_r;
        end else if (paddr == `CHIP_CFG_OFFSET) begin
            rd_nxt[`CHIP_CFG_CORE_LSB +: 4]  = core_ratio_select_r;
            rd_nxt[`CHIP_CFG_EXT_LSB +: 2]   = ext_clock_divider_select_r;
            rd_nxt[`CHIP_CFG_BUS_BIT]        = bus_mult_sel_r;
            rd_nxt[`CHIP_CFG_RATIO_LSB +: 6] = ratio_r;
        end else if (paddr == `SDRAM_DATA_OFFSET) begin
            rd_nxt = sdram_data_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_config_register_r <= `PIN_CFG_RESET;
        end else if (wr_en && paddr == `PIN_CFG_OFFSET) begin
            pin_config_register_r <= {27'h000_0000, pwdata[4:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= psel && !penable;
            pslverr_r <= psel && !penable && !map_hit;
            if (psel && !penable) begin
                prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
            end
        end
    end

    assign prdata                 = prdata_r;
    assign pready                 = pready_r;
    assign pslverr                = pslverr_r;
    assign core_ratio_x2          = ratio_r;
    assign system_bus_clock       = sys_r;
    assign peripheral_bus_clock   = per_r;
    assign external_bus_clock_out = ext_r;
    assign sdram_clock_out        = sdram_r;

    // Assertions
    sys_fast_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
        strap_valid_r && !bus_mult_sel_r |=> sys_r != $past(sys_r))
        else $error("bus clock not at fast rate");
    sys_slow_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
        strap_valid_r && bus_mult_sel_r && $rose(sys_r) |-> sys_r [*4])
        else $error("bus clock high phase not four cycles");
    per_half_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(sys_r) |-> per_r != $past(per_r))
        else $error("peripheral clock not half bus clock");
    per_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(sys_r) |-> $stable(per_r))
        else $error("peripheral clock moved on falling bus edge");
    ext_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pin_config_register_r[`PIN_CFG_EXT_EN_BIT] |=> !ext_r)
        else $error("external clock pulses while disabled");
    ext_div1_a: assert property (@(posedge pclk) disable iff (!presetn)
        strap_valid_r && ext_clock_divider_select_r == 2'h3 &&
        pin_config_register_r[`PIN_CFG_EXT_EN_BIT] |=> ext_r == sys_r)
        else $error("external clock not equal to bus clock");
    sdram_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        pin_config_register_r[0] |=> sdram_r[0] == sys_r)
        else $error("sdram clock does not follow bus clock");
    sdram_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pin_config_register_r[1] |=> !sdram_r[1])
        else $error("gated sdram clock still pulses");
    fb_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
        fb_s2_r && !fb_s3_r |=> sdram_data_r == $past(data_s2_r))
        else $error("read data not latched on feedback edge");
    strap_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        strap_valid_r |-> $stable(core_ratio_select_r) && $stable(ratio_r))
        else $error("strap ratio changed after reset");
    apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready_r)
        else $error("access phase without ready");

    slow_bus_c: cover property (@(posedge pclk) disable iff (!presetn)
        bus_mult_sel_r && $rose(sys_r));
    ext_div3_c: cover property (@(posedge pclk) disable iff (!presetn)
        ext_clock_divider_select_r == 2'h1 && $rose(ext_r));
    ext_div4_c: cover property (@(posedge pclk) disable iff (!presetn)
        ext_clock_divider_select_r == 2'h0 && $rose(ext_r));
    apb_write_c: cover property (@(posedge pclk) disable iff (!presetn)
        wr_en);
    fb_edge_c: cover property (@(posedge pclk) disable iff (!presetn)
        fb_s2_r && !fb_s3_r);
endmodule
`default_nettype wire

// >>> hdl/clock_tree_defines.svh
// Offsets, field positions, reset values and bus step counts of the clock tree.
// Assumes inclusion by bare name from the design files only.
`ifndef CLOCK_TREE_DEFINES_SVH
`define CLOCK_TREE_DEFINES_SVH

`define PIN_CFG_OFFSET      12'h000
`define CHIP_CFG_OFFSET     12'h004
`define SDRAM_DATA_OFFSET   12'h008

`define PIN_CFG_SDRAM_LSB   0
`define PIN_CFG_EXT_EN_BIT  4
`define PIN_CFG_RESET       32'h0000_001f

`define CHIP_CFG_CORE_LSB   0
`define CHIP_CFG_EXT_LSB    4
`define CHIP_CFG_BUS_BIT    6
`define CHIP_CFG_RATIO_LSB  8

`define STRAP_CORE_RESET    4'hf
`define STRAP_EXT_RESET     2'h3
`define STRAP_BUS_RESET     1'h0

`define SYS_STEP_FAST       2'h0
`define SYS_STEP_SLOW       2'h3

`endif

// >>> hdl/clock_tree_pkg.sv
// Types shared by the clock tree design.
// Assumes the defines header is compiled alongside.
package clock_tree_pkg;
    typedef logic [3:0] core_ratio_select_t;
    typedef logic [1:0] ext_clock_divider_select_t;
    typedef logic [5:0] ratio_x2_t;
endpackage

// >>> testbench/sdram_partner.sv
// SDRAM side model: feedback trace and read data pins.
// Assumes the bench sets the word that the SDRAM presents.
`timescale 1ns/10ps
`default_nettype none
module sdram_partner (
    input  wire logic        sdram_clock_in,
    input  wire logic [31:0] word,
    output logic             feedback_clock,
    output logic      [31:0] read_data
);
    // Board trace returns the first SDRAM clock to the feedback pin
    assign feedback_clock = sdram_clock_in;
    assign read_data = word;
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// Bench for the clock tree: strap rows, then gating and register cases.
// Assumes the design and the SDRAM model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    typedef struct {
        logic [3:0] c;
        logic       b;
        logic [1:0] e;
        logic [5:0] x;
    } row_t;
    logic        pclk, presetn, psel, penable, pwrite, bus_mult, fb_clk;
    logic        pready, pslverr, err, bus_clk, per_clk, ext_clk;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, sd_data, sd_word, rd;
    logic [3:0]  core_sel, sd_clk;
    logic [1:0]  ext_sel;
    logic [5:0]  ratio_x2;
    wire  logic [6:0] probe;
    int          failures, samples_checked, p, bp;
    row_t        rows [5];

    assign probe = {ext_clk, per_clk, bus_clk, sd_clk};

    boot_strapped_clock_tree DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .strap_core_ratio(core_sel),
        .strap_bus_mult(bus_mult), .strap_ext_div(ext_sel),
        .sdram_feedback_clock(fb_clk), .sdram_read_data(sd_data),
        .core_ratio_x2(ratio_x2), .system_bus_clock(bus_clk),
        .peripheral_bus_clock(per_clk), .external_bus_clock_out(ext_clk),
        .sdram_clock_out(sd_clk)
    );

    sdram_partner far_side (
        .sdram_clock_in(sd_clk[0]), .word(sd_word),
        .feedback_clock(fb_clk), .read_data(sd_data)
    );

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees ready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Cycles between two rising edges of one probe bit, 0 if none
    task automatic period(input int k, output int n);
        logic last;
        int   rises;
        rises = 0;
        n = 0;
        last = 1'b1;
        for (int i = 0; i < 300 && rises < 2; i++) begin
            @(posedge pclk);
            #1;
            if (rises == 1)
                n++;
            if (probe[k] === 1'b1 && last === 1'b0)
                rises++;
            last = probe[k];
        end
        if (rises < 2)
            n = 0;
    endtask

    task automatic do_reset(input logic [3:0] c, input logic b,
                            input logic [1:0] e);
        @(posedge pclk);
        presetn <= 1'b0;
        core_sel <= c;
        bus_mult <= b;
        ext_sel <= e;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    initial begin
        #200000;
        failures++;
        wrap_up();
    end

    initial begin
        {presetn, psel, penable, pwrite, bus_mult} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        core_sel = 4'hf;
        ext_sel = 2'h3;
        sd_word = 32'h1234_5678;
        // Strap rows; ext divider chosen to suit the bus devices
        rows = '{'{4'hf, 1'b0, 2'h3, 6'h04}, '{4'h3, 1'b1, 2'h0, 6'h24},
                 '{4'h7, 1'b0, 2'h1, 6'h09}, '{4'h8, 1'b1, 2'h2, 6'h20},
                 '{4'h0, 1'b0, 2'h0, 6'h04}};
        foreach (rows[i]) begin
            do_reset(rows[i].c, rows[i].b, rows[i].e);
            repeat (4) @(posedge pclk);
            bp = rows[i].b ? 8 : 2;
            check("core ratio", 32'(ratio_x2), 32'(rows[i].x));
            period(4, p);
            check("bus period", 32'(p), 32'(bp));
            period(5, p);
            check("periph period", 32'(p), 32'(2 * bp));
            period(6, p);
            check("ext period", 32'(p), 32'(bp * (4 - rows[i].e)));
            period(3, p);
            check("sdram period", 32'(p), 32'(bp));
            apb(1'b0, 12'h004, 32'h0000_0000);
            check("chip cfg", rd, {18'h0_0000, rows[i].x, 1'b0, rows[i].b,
                                   rows[i].e, rows[i].c});
            $display("row %0d done", i);
        end
        core_sel <= 4'h3;
        bus_mult <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0000_0000);
        check("held straps", rd, 32'h0000_0400);
        apb(1'b0, 12'h00c, 32'h0000_0000);
        check("unmapped err", 32'(err), 32'h0000_0001);
        apb(1'b1, 12'h00c, 32'h0000_0000);
        apb(1'b0, 12'h000, 32'h0000_0000);
        check("pin cfg", rd, 32'h0000_001f);
        apb(1'b0, 12'h008, 32'h0000_0000);
        check("sdram word", rd, 32'h1234_5678);
        apb(1'b1, 12'h000, 32'h0000_000e);
        repeat (4) @(posedge pclk);
        period(6, p);
        check("ext gated", 32'(p), 32'h0000_0000);
        period(0, p);
        check("sdram0 gated", 32'(p), 32'h0000_0000);
        period(1, p);
        check("sdram1 running", 32'(p), 32'h0000_0002);
        sd_word <= 32'hcafe_0042;
        repeat (20) @(posedge pclk);
        apb(1'b0, 12'h008, 32'h0000_0000);
        check("no feedback", rd, 32'h1234_5678);
        apb(1'b1, 12'h000, 32'h0000_001f);
        repeat (20) @(posedge pclk);
        apb(1'b0, 12'h008, 32'h0000_0000);
        check("feedback word", rd, 32'hcafe_0042);
        period(6, p);
        check("ext restarted", 32'(p), 32'h0000_0008);
        $display("gating and register cases done");
        wrap_up();
    end
endmodule
`default_nettype wire
